// >>> src/sacs_cmd.v
/*
 Servo ASCII command interpreter: frames host command lines, executes profile
 starts, memory reads, position, limit and flag commands, and answers each one addressed to this controller.
 Assumes received bytes come from a serial receiver on ref_clk with a strobe,
 that motion, memory and actual position logic sit outside this block.
*/
`timescale 1ns/1ps
`include "sacs_map.vh"
module sacs_cmd #(
   parameter [16:0] CTRL_ID = 17'h00001
) (
   input  wire        ref_clk,
   input  wire        srst,
   input  wire [7:0]  rx_data,
   input  wire        rx_valid,
   output wire        rx_ready,
   output wire [7:0]  tx_data,
   output wire        tx_valid,
   input  wire        tx_ready,
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   output reg         mem_rd,
   output reg  [15:0] mem_addr,
   input  wire [15:0] mem_rdata,
   input  wire [63:0] act_pos,
   input  wire        stop_flag,
   input  wire        prof_busy,
   output reg         prof_start,
   output reg         prof_abort,
   output reg  [5:0]  prof_index,
   output reg  [1:0]  prof_axis,
   output reg         prof_at_actual,
   output reg         act_load,
   output reg  [1:0]  act_load_axis,
   output reg  [15:0] act_load_value,
   output reg  [63:0] demand_pos,
   output reg  [63:0] curve_offset,
   output reg  [63:0] accel_lim,
   output reg  [63:0] curr_lim,
   output reg         run_flag,
   output reg         init_flag,
   output reg         hold_global,
   output reg  [3:0]  hold_axis,
   output wire [3:0]  move_enable
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_C1   = 3'h1;
   localparam [2:0] ST_C2   = 3'h2;
   localparam [2:0] ST_PARM = 3'h3;
   localparam [2:0] ST_EXEC = 3'h4;
   localparam [2:0] ST_MEM  = 3'h5;
   localparam [2:0] ST_SEND = 3'h6;

   reg  [2:0]  st;
   reg  [15:0] code;
   reg         neg;
   reg         sgn_seen;
   reg         sgn_plus;
   reg         drv_seen;
   reg  [1:0]  drv;
   reg         bad;
   reg         inc_after;
   reg         fmt_start;
   reg  [15:0] rep_val;
   wire [16:0] mag;
   wire [2:0]  ndig;
   wire        fmt_busy;

   wire        take    = rx_valid && rx_ready;
   wire        is_dig  = (rx_data >= `SACS_CH_ZERO) && (rx_data <= `SACS_CH_NINE);
   wire        is_axis = (rx_data >= `SACS_CH_AXIS_A) && (rx_data <= `SACS_CH_AXIS_D);
   wire        acc_clr = (st == ST_C2) && take;
   wire [7:0]  dig_off = rx_data - `SACS_CH_ZERO;
   wire [7:0]  axs_off = rx_data - `SACS_CH_AXIS_A;

   // No buffer: bytes are refused while a command executes or replies
   assign rx_ready = (st == ST_IDLE) || (st == ST_C1) || (st == ST_C2) || (st == ST_PARM);

   sacs_dec_acc u_acc (
      .ref_clk     (ref_clk),
      .srst        (srst),
      .clear       (acc_clr),
      .digit_valid (take && st == ST_PARM && is_dig),
      .digit       (dig_off[3:0]),
      .mag         (mag),
      .ndig        (ndig)
   );

   sacs_dec_fmt u_fmt (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .start    (fmt_start),
      .value    (rep_val),
      .tx_ready (tx_ready),
      .tx_data  (tx_data),
      .tx_valid (tx_valid),
      .busy     (fmt_busy)
   );

   // Operand checks
   wire        has_num  = (ndig != 3'h0);
   // An axis letter means this controller; a flag sign is no number sign
   wire        for_us   = drv_seen || !has_num || (mag == CTRL_ID);
   wire        axis_num = drv_seen && has_num;
   wire        pos_ok   = axis_num && (mag <= `SACS_POS_MAX);
   wire        uns_ok   = axis_num && !neg && !sgn_seen;
   wire [15:0] sval     = neg ? (16'h0000 - mag[15:0]) : mag[15:0];
   wire        flag_ok  = sgn_seen && has_num && !drv_seen;
   wire [5:0]  sh       = {drv, 4'h0};

   assign move_enable = ~hold_axis & {4{~hold_global}};

   always @(posedge ref_clk) begin
      if (srst) begin
         st             <= ST_IDLE;
         code           <= 16'h0000;
         neg            <= 1'b0;
         sgn_seen       <= 1'b0;
         sgn_plus       <= 1'b0;
         drv_seen       <= 1'b0;
         drv            <= 2'h0;
         bad            <= 1'b0;
         inc_after      <= 1'b0;
         fmt_start      <= 1'b0;
         rep_val        <= 16'h0000;
         mem_rd         <= 1'b0;
         mem_addr       <= `SACS_RST_ADDR;
         prof_start     <= 1'b0;
         prof_abort     <= 1'b0;
         prof_index     <= 6'h00;
         prof_axis      <= 2'h0;
         prof_at_actual <= 1'b0;
         act_load       <= 1'b0;
         act_load_axis  <= 2'h0;
         act_load_value <= 16'h0000;
         demand_pos     <= {4{`SACS_RST_POS}};
         curve_offset   <= {4{`SACS_RST_POS}};
         accel_lim      <= {4{`SACS_RST_ACC}};
         curr_lim       <= {4{`SACS_RST_CUR}};
         run_flag       <= 1'b0;
         init_flag      <= 1'b0;
         hold_global    <= 1'b0;
         hold_axis      <= 4'h0;
      end else begin
         fmt_start  <= 1'b0;
         mem_rd     <= 1'b0;
         prof_start <= 1'b0;
         prof_abort <= 1'b0;
         act_load   <= 1'b0;
         if (reg_wr && reg_addr == `SACS_REG_MEMADDR && st != ST_MEM)
            mem_addr <= reg_wdata;
         case (st)
            ST_IDLE: if (take && rx_data == `SACS_CH_START)
               st <= ST_C1;
            ST_C1: if (take) begin
               code[15:8] <= rx_data;
               st <= (rx_data == `SACS_CH_CR) ? ST_IDLE : ST_C2;
            end
            ST_C2: if (take) begin
               code[7:0] <= rx_data;
               neg      <= 1'b0;
               sgn_seen <= 1'b0;
               sgn_plus <= 1'b0;
               drv_seen <= 1'b0;
               drv      <= 2'h0;
               bad      <= 1'b0;
               st <= (rx_data == `SACS_CH_CR) ? ST_IDLE : ST_PARM;
            end
            ST_PARM: if (take) begin
               if (rx_data == `SACS_CH_CR) begin
                  st <= ST_EXEC;
               end else if (rx_data == `SACS_CH_START) begin
                  // A fresh start mark drops a broken line and begins anew
                  st <= ST_C1;
               end else if (is_dig && !drv_seen) begin
                  bad <= bad;
               end else if ((rx_data == `SACS_CH_PLUS || rx_data == `SACS_CH_MINUS)
                            && !sgn_seen && !has_num && !drv_seen) begin
                  sgn_seen <= 1'b1;
                  sgn_plus <= (rx_data == `SACS_CH_PLUS);
                  neg      <= (rx_data == `SACS_CH_MINUS);
               end else if (is_axis && !drv_seen) begin
                  drv_seen <= 1'b1;
                  drv      <= axs_off[1:0];
               end else begin
                  bad <= 1'b1;
               end
            end
            ST_EXEC: begin
               rep_val   <= `SACS_ACK_NAK;
               fmt_start <= 1'b1;
               inc_after <= 1'b0;
               st        <= ST_SEND;
               if (!for_us && !bad) begin
                  // Another controller is addressed: stay silent
                  fmt_start <= 1'b0;
                  st        <= ST_IDLE;
               end else if (!bad) begin
                  case (code)
                     `SACS_CMD_RUN_ACT, `SACS_CMD_RUN_PROF:
                        if (run_flag && uns_ok && mag <= `SACS_PROF_MAX) begin
                           prof_start     <= 1'b1;
                           prof_index     <= mag[5:0];
                           prof_axis      <= drv;
                           prof_at_actual <= (code == `SACS_CMD_RUN_ACT);
                           prof_abort     <= prof_busy;
                           rep_val        <= `SACS_ACK_OK;
                           if (code == `SACS_CMD_RUN_ACT)
                              curve_offset[sh +: 16] <= demand_pos[sh +: 16];
                        end
                     `SACS_CMD_READ, `SACS_CMD_READ_INC:
                        if (drv_seen && !has_num && !sgn_seen) begin
                           mem_rd    <= 1'b1;
                           fmt_start <= 1'b0;
                           inc_after <= (code == `SACS_CMD_READ_INC);
                           st        <= ST_MEM;
                        end
                     `SACS_CMD_REDEF:
                        if (run_flag && pos_ok) begin
                           act_load       <= 1'b1;
                           act_load_axis  <= drv;
                           act_load_value <= sval;
                           rep_val        <= `SACS_ACK_OK;
                        end
                     `SACS_CMD_DEM_ACT:
                        if (drv_seen && !has_num && !sgn_seen) begin
                           demand_pos[sh +: 16] <= act_pos[sh +: 16];
                           rep_val              <= `SACS_ACK_OK;
                        end
                     `SACS_CMD_ACCEL:
                        if (uns_ok && mag >= `SACS_ACC_MIN && mag <= `SACS_ACC_MAX) begin
                           accel_lim[sh +: 16] <= mag[15:0];
                           rep_val             <= `SACS_ACK_OK;
                        end
                     `SACS_CMD_CURR:
                        if (uns_ok && mag <= `SACS_CUR_MAX) begin
                           curr_lim[sh +: 16] <= mag[15:0];
                           rep_val            <= `SACS_ACK_OK;
                        end
                     `SACS_CMD_HOLD:
                        if (sgn_seen && drv_seen) begin
                           hold_axis[drv] <= sgn_plus;
                           rep_val        <= `SACS_ACK_OK;
                        end else if (flag_ok) begin
                           hold_global <= sgn_plus;
                           rep_val     <= `SACS_ACK_OK;
                        end
                     `SACS_CMD_INIT:
                        if (flag_ok) begin
                           init_flag <= sgn_plus;
                           rep_val   <= `SACS_ACK_OK;
                        end
                     `SACS_CMD_RUNFLAG:
                        if (flag_ok) begin
                           run_flag <= sgn_plus;
                           rep_val  <= `SACS_ACK_OK;
                        end
                     `SACS_CMD_DEMAND:
                        if (pos_ok) begin
                           demand_pos[sh +: 16] <= sval;
                           rep_val              <= `SACS_ACK_OK;
                        end
                     `SACS_CMD_FLAGS:
                        if (has_num && !drv_seen && !sgn_seen)
                           rep_val <= {8'h00, run_flag, init_flag, hold_global, stop_flag,
                                       hold_axis};
                     default:
                        rep_val <= `SACS_ACK_NAK;
                  endcase
               end
            end
            ST_MEM: begin
               rep_val   <= mem_rdata;
               fmt_start <= 1'b1;
               if (inc_after)
                  mem_addr <= mem_addr + `SACS_ADDR_STEP;
               st <= ST_SEND;
            end
            ST_SEND: if (!fmt_start && !fmt_busy)
               st <= ST_IDLE;
            default: st <= ST_IDLE;
         endcase
      end
   end

   // Register port: read data in the cycle after the strobe
   always @(posedge ref_clk) begin
      if (srst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `SACS_REG_FLAGS:   reg_rdata <= {8'h00, run_flag, init_flag, hold_global, stop_flag,
                                             hold_axis};
            `SACS_REG_MEMADDR: reg_rdata <= mem_addr;
            `SACS_REG_LASTREP: reg_rdata <= rep_val;
            default:           reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
endmodule // sacs_cmd

// >>> src/sacs_map.vh
/*
 Constants of the servo ASCII command interpreter: characters, command codes,
 limits, flag bit positions, register offsets and reset values.
 Assumes it is included once per design file by its bare name.
*/
`ifndef SACS_MAP_VH
`define SACS_MAP_VH

// Framing, sign, digit and axis characters
`define SACS_CH_START      8'h21
`define SACS_CH_REPLY      8'h23
`define SACS_CH_CR         8'h0D
`define SACS_CH_PLUS       8'h2B
`define SACS_CH_MINUS      8'h2D
`define SACS_CH_ZERO       8'h30
`define SACS_CH_NINE       8'h39
`define SACS_CH_AXIS_A     8'h41
`define SACS_CH_AXIS_D     8'h44

// Two-letter command codes, first letter in the upper byte
`define SACS_CMD_RUN_ACT   16'h5241
`define SACS_CMD_RUN_PROF  16'h5243
`define SACS_CMD_READ      16'h5244
`define SACS_CMD_READ_INC  16'h5245
`define SACS_CMD_REDEF     16'h5250
`define SACS_CMD_DEM_ACT   16'h5251
`define SACS_CMD_ACCEL     16'h5341
`define SACS_CMD_CURR      16'h5343
`define SACS_CMD_HOLD      16'h5346
`define SACS_CMD_INIT      16'h5349
`define SACS_CMD_DEMAND    16'h5350
`define SACS_CMD_RUNFLAG   16'h5352
`define SACS_CMD_FLAGS     16'h4758

// Parameter limits and read address step
`define SACS_PROF_MAX      17'h0003F
`define SACS_POS_MAX       17'h07E00
`define SACS_ACC_MIN       17'h00001
`define SACS_ACC_MAX       17'h00600
`define SACS_CUR_MAX       17'h00100
`define SACS_ADDR_STEP     16'h0002

// Acknowledge codes
`define SACS_ACK_OK        16'h0000
`define SACS_ACK_NAK       16'h0001

// Flag word bit positions
`define SACS_FLG_RUN       7
`define SACS_FLG_INIT      6
`define SACS_FLG_GFRZ      5
`define SACS_FLG_STOP      4

// Register offsets on the plain port
`define SACS_REG_FLAGS     4'h0
`define SACS_REG_MEMADDR   4'h1
`define SACS_REG_LASTREP   4'h2

// Reset values
`define SACS_RST_POS       16'h0000
`define SACS_RST_ACC       16'h0600
`define SACS_RST_CUR       16'h0100
`define SACS_RST_ADDR      16'h0000

`endif

// >>> src/sacs_dec_acc.v
/*
 Decimal digit accumulator of the command parser.
 Assumes digits arrive as binary 0..9 with a one-cycle strobe on ref_clk.
*/
`timescale 1ns/1ps
module sacs_dec_acc (
   input  wire        ref_clk,
   input  wire        srst,
   input  wire        clear,
   input  wire        digit_valid,
   input  wire [3:0]  digit,
   output reg  [16:0] mag,
   output reg  [2:0]  ndig
);
   wire [20:0] prod = {4'h0, mag} * 21'h00000A + {17'h00000, digit};

   // Saturates so an overlong number still fails every range check
   always @(posedge ref_clk) begin
      if (srst || clear) begin
         mag  <= 17'h00000;
         ndig <= 3'h0;
      end else if (digit_valid) begin
         mag  <= (prod > 21'h01FFFF) ? 17'h1FFFF : prod[16:0];
         ndig <= (ndig == 3'h7) ? ndig : ndig + 3'h1;
      end
   end
endmodule // sacs_dec_acc

// >>> src/sacs_dec_fmt.v
/*
 Reply formatter: sends the reply mark, an unsigned decimal value without
 leading zeros, and a carriage return, one byte per tx handshake.
 Assumes the serial sender takes a byte when tx_valid and tx_ready are high.
*/
`timescale 1ns/1ps
`include "sacs_map.vh"
module sacs_dec_fmt (
   input  wire        ref_clk,
   input  wire        srst,
   input  wire        start,
   input  wire [15:0] value,
   input  wire        tx_ready,
   output reg  [7:0]  tx_data,
   output reg         tx_valid,
   output wire        busy
);
   localparam [1:0] F_IDLE = 2'h0;
   localparam [1:0] F_HASH = 2'h1;
   localparam [1:0] F_DIG  = 2'h2;
   localparam [1:0] F_CR   = 2'h3;

   reg  [1:0]  st;
   reg  [15:0] rem;
   reg  [2:0]  k;
   reg  [3:0]  cnt;
   reg         lead;
   reg  [15:0] pw;
   wire        slot = !tx_valid || tx_ready;

   // Powers of ten, largest first
   always @* begin
      case (k)
         3'h0:    pw = 16'h2710;
         3'h1:    pw = 16'h03E8;
         3'h2:    pw = 16'h0064;
         3'h3:    pw = 16'h000A;
         default: pw = 16'h0001;
      endcase
   end

   assign busy = (st != F_IDLE) || tx_valid;

   // Digits by repeated subtraction; slow but tiny beside the serial rate
   always @(posedge ref_clk) begin
      if (srst) begin
         st       <= F_IDLE;
         rem      <= 16'h0000;
         k        <= 3'h0;
         cnt      <= 4'h0;
         lead     <= 1'b0;
         tx_data  <= 8'h00;
         tx_valid <= 1'b0;
      end else begin
         if (tx_valid && tx_ready)
            tx_valid <= 1'b0;
         case (st)
            F_IDLE: if (start) begin
               rem  <= value;
               k    <= 3'h0;
               cnt  <= 4'h0;
               lead <= 1'b0;
               st   <= F_HASH;
            end
            F_HASH: if (slot) begin
               tx_data  <= `SACS_CH_REPLY;
               tx_valid <= 1'b1;
               st       <= F_DIG;
            end
            F_DIG: if (rem >= pw) begin
               rem <= rem - pw;
               cnt <= cnt + 4'h1;
            end else if (cnt == 4'h0 && !lead && k != 3'h4) begin
               k <= k + 3'h1;
            end else if (slot) begin
               tx_data  <= `SACS_CH_ZERO + {4'h0, cnt};
               tx_valid <= 1'b1;
               lead     <= 1'b1;
               cnt      <= 4'h0;
               k        <= k + 3'h1;
               if (k == 3'h4)
                  st <= F_CR;
            end
            F_CR: if (slot) begin
               tx_data  <= `SACS_CH_CR;
               tx_valid <= 1'b1;
               st       <= F_IDLE;
            end
            default: st <= F_IDLE;
         endcase
      end
   end
endmodule // sacs_dec_fmt

// >>> test/sacs_cmd_monitor.sv
/*
 Checker for the command interpreter ports.
 Bound to sacs_cmd; one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module sacs_cmd_monitor (
   input logic        ref_clk,
   input logic        srst,
   input logic        rx_ready,
   input logic [7:0]  tx_data,
   input logic        tx_valid,
   input logic        tx_ready,
   input logic [3:0]  reg_addr,
   input logic        reg_rd,
   input logic [15:0] reg_rdata,
   input logic        mem_rd,
   input logic [15:0] mem_addr,
   input logic        stop_flag,
   input logic        prof_start,
   input logic        prof_abort,
   input logic        act_load,
   input logic        run_flag,
   input logic        init_flag,
   input logic        hold_global,
   input logic [3:0]  hold_axis,
   input logic [3:0]  move_enable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   move_gate_a: assert property (move_enable == (~hold_axis & {4{~hold_global}}))
      else $error("axis enable wrong");
   abort_start_a: assert property (prof_abort |-> prof_start)
      else $error("abort without start");
   start_run_a: assert property (prof_start |-> run_flag)
      else $error("start outside run");
   load_run_a: assert property (act_load |-> run_flag)
      else $error("redefine outside run");
   start_pulse_a: assert property (prof_start |=> !prof_start)
      else $error("start pulse too long");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply byte dropped");
   tx_busy_a: assert property (tx_valid |-> !rx_ready)
      else $error("input open while replying");
   mem_step_a: assert property (mem_rd |-> ##2 (mem_addr == $past(mem_addr, 2) ||
      mem_addr == $past(mem_addr, 2) + 16'h0002))
      else $error("address step wrong");
   flags_word_a: assert property (reg_rd && reg_addr == 4'h0 |=>
      reg_rdata[7:0] == {$past(run_flag), $past(init_flag), $past(hold_global), $past(stop_flag),
      $past(hold_axis)})
      else $error("flag word wrong");
   cover property (prof_start && prof_abort);
   cover property (mem_rd);
   cover property (act_load);
endmodule // sacs_cmd_monitor

bind sacs_cmd sacs_cmd_monitor mon (.ref_clk, .srst, .rx_ready, .tx_data, .tx_valid, .tx_ready,
   .reg_addr, .reg_rd, .reg_rdata, .mem_rd, .mem_addr, .stop_flag, .prof_start, .prof_abort,
   .act_load, .run_flag, .init_flag, .hold_global, .hold_axis, .move_enable);

// >>> test/sacs_host_model.sv
/*
 Host model: sends command lines byte by byte, collects the reply value.
 Assumes it shares ref_clk with the interpreter.
*/
`timescale 1ns/1ps
module sacs_host_model (
   input  logic       ref_clk,
   output logic [7:0] rx_data,
   output logic       rx_valid,
   input  logic       rx_ready,
   input  logic [7:0] tx_data,
   input  logic       tx_valid,
   output logic       tx_ready
);
   bit slow = 1'h0;
   bit done = 1'h0;
   int val  = 0;
   initial begin
      rx_data = 8'h00;
      rx_valid = 1'h0;
   end
   always @(posedge ref_clk) begin
      tx_ready <= !slow || !tx_ready;
      if (tx_valid && tx_ready) begin
         if (tx_data == 8'h23)
            val <= 0;
         else if (tx_data == 8'h0D)
            done <= 1'h1;
         else
            val <= val * 10 + (tx_data - 8'h30);
      end
   end
   task send(input string s);
      bit ok;
      @(posedge ref_clk);
      done <= 1'h0;
      for (int i = 0; i <= s.len(); i++) begin
         rx_data <= (i == s.len()) ? 8'h0D : s[i];
         rx_valid <= 1'h1;
         do begin
            @(negedge ref_clk);
            ok = rx_ready;
            @(posedge ref_clk);
         end while (!ok);
      end
      rx_valid <= 1'h0;
      // Released line shows a changed value, not the last byte
      rx_data <= ~rx_data;
   endtask
   task get(output int v);
      int k;
      k = 0;
      while (!done && k < 400) begin
         @(negedge ref_clk);
         k++;
      end
      v = done ? val : -1;
   endtask
endmodule // sacs_host_model

// >>> test/sacs_cmd_tb_top.sv
/*
 Self-checking bench of the command interpreter.
 Host model on the serial side; memory answers address xor a key.
*/
`timescale 1ns/1ps
module sacs_cmd_tb_top;
   localparam int OK = 32'h0;
   localparam int NK = 32'h1;
   logic        ref_clk = 1'h0;
   logic        srst = 1'h1;
   logic        stop_flag = 1'h1;
   logic        prof_busy = 1'h0;
   logic        reg_wr = 1'h0;
   logic        reg_rd = 1'h0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic [63:0] act_pos = 64'h0000000000000000;
   logic [7:0]  rx_data, tx_data;
   logic        rx_valid, rx_ready, tx_valid, tx_ready, mem_rd, act_load;
   logic        prof_start, prof_abort, prof_at_actual, run_flag, init_flag, hold_global;
   logic [1:0]  prof_axis, act_load_axis;
   logic [5:0]  prof_index;
   logic [3:0]  hold_axis, move_enable;
   logic [15:0] reg_rdata, mem_addr, act_load_value;
   logic [63:0] demand_pos, curve_offset, accel_lim, curr_lim;
   wire  [15:0] mem_rdata = mem_addr ^ 16'h5A5A;
   int          n_errors = 0;
   int          checks_done = 0;
   int          n_start = 0;
   int          n_abort = 0;

   sacs_cmd DUT (
      .ref_clk(ref_clk), .srst(srst), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_rd(mem_rd),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .act_pos(act_pos), .stop_flag(stop_flag),
      .prof_busy(prof_busy), .prof_start(prof_start), .prof_abort(prof_abort), .prof_index(prof_index),
      .prof_axis(prof_axis), .prof_at_actual(prof_at_actual), .act_load(act_load),
      .act_load_axis(act_load_axis), .act_load_value(act_load_value), .demand_pos(demand_pos),
      .curve_offset(curve_offset), .accel_lim(accel_lim), .curr_lim(curr_lim), .run_flag(run_flag),
      .init_flag(init_flag), .hold_global(hold_global), .hold_axis(hold_axis), .move_enable(move_enable));
   sacs_host_model host (
      .ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

   initial forever #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (prof_start === 1'h1) n_start++;
      if (prof_abort === 1'h1) n_abort++;
   end
   initial begin
      #200000;
      n_errors++;
      finish_test;
   end

   task finish_test;
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask
   task cmd(input string s, input int e);
      int v;
      host.send(s);
      host.get(v);
      chk(v, e);
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask
   task rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask

   task t_reset;
      @(negedge ref_clk);
      chk(accel_lim, {4{16'h0600}});
      chk(curr_lim, {4{16'h0100}});
      chk(move_enable, 4'hF);
      cmd("!GX1", 32'h10);
   endtask
   task t_flags;
      logic [15:0] d;
      cmd("!SR+1", OK);
      cmd("!SI+1", OK);
      cmd("!SF+1", OK);
      cmd("!SF+B", OK);
      chk(move_enable, 4'h0);
      cmd("!GX1", 32'hF2);
      rd(4'h0, d);
      chk(d[7:0], 8'hF2);
      cmd("!SF-1", OK);
      chk(move_enable, 4'hD);
      cmd("!SI-1", OK);
      cmd("!SF-B", OK);
      @(posedge ref_clk) stop_flag <= 1'h0;
      cmd("!GX1", 32'h80);
   endtask
   task t_prof;
      cmd("!SR-1", OK);
      cmd("!RC5A", NK);
      chk(n_start, 32'h0);
      cmd("!SR+1", OK);
      @(posedge ref_clk) prof_busy <= 1'h1;
      cmd("!RC63B", OK);
      chk({prof_index, prof_axis, prof_at_actual, 32'(n_abort)}, {6'h3F, 2'h1, 1'h0, 32'h1});
      @(posedge ref_clk) prof_busy <= 1'h0;
      cmd("!SP300C", OK);
      cmd("!RA0C", OK);
      chk({prof_index, prof_axis, prof_at_actual, 32'(n_abort)}, {6'h00, 2'h2, 1'h1, 32'h1});
      chk(curve_offset[47:32], 16'h012C);
      cmd("!RC64A", NK);
      chk(n_start, 32'h2);
   endtask
   task t_lim;
      cmd("!SA1A", OK);
      cmd("!SA0A", NK);
      cmd("!SA1537A", NK);
      chk(accel_lim[15:0], 16'h0001);
      cmd("!SA1536B", OK);
      cmd("!SC0C", OK);
      cmd("!SC257C", NK);
      cmd("!SC256D", OK);
      chk(curr_lim[47:32], 16'h0000);
      cmd("!SP-32256D", OK);
      cmd("!SP32256B", OK);
      cmd("!SP32257A", NK);
      chk({demand_pos[63:48], demand_pos[31:0]}, {16'h8200, 16'h7E00, 16'h0000});
   endtask
   task t_pos;
      cmd("!RP-100B", OK);
      chk({act_load_axis, act_load_value}, {2'h1, 16'hFF9C});
      cmd("!RP32257B", NK);
      @(posedge ref_clk) act_pos <= 64'h0000000000001234;
      cmd("!RQA", OK);
      chk(demand_pos[15:0], 16'h1234);
   endtask
   task t_mem;
      logic [15:0] d;
      host.slow = 1'h1;
      wr(4'h1, 16'h0100);
      cmd("!RDA", 32'h5B5A);
      rd(4'h1, d);
      chk(d, 16'h0100);
      cmd("!RED", 32'h5B5A);
      rd(4'h1, d);
      chk(d, 16'h0102);
      cmd("!REA", 32'h5B58);
      rd(4'h5, d);
      chk(d, 16'h0000);
      host.slow = 1'h0;
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      srst <= 1'h0;
      t_reset;
      t_flags;
      t_prof;
      t_lim;
      t_pos;
      t_mem;
      finish_test;
   end
endmodule // sacs_cmd_tb_top
